// File: design/hka_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef HKA_MAP_SVH
`define HKA_MAP_SVH
`define HKA_ADDR_TEMP_RESULT 8'hD7
`define HKA_ADDR_START       8'hD8
`define HKA_ADDR_BATT_RESULT 8'hDF
`define HKA_ADDR_PIRQ_EN     8'hEC
`define HKA_ADDR_EXT_RESULT  8'hEF
`define HKA_ADDR_DELTA       8'hF3
`define HKA_ADDR_PERIPHERAL_CONFIG_REG      8'hF4
`define HKA_ADDR_PIRQ_FLAGS  8'hF8
`define HKA_ADDR_STROBE      8'hF9
`define HKA_ADDR_BATT_THRESH 8'hFA
`define HKA_BIT_BATT_GO      0
`define HKA_BIT_TEMP_GO      1
`define HKA_BIT_EXT_GO       2
`define HKA_BIT_PLL_ACK      7
`define HKA_BIT_PLL_FAULT_FLAG      4
`define HKA_BIT_BATT_LOW     2
`define HKA_STRB_TEMP_LSB    0
`define HKA_STRB_BATT_LSB    2
`define HKA_DELTA_TEMP_LSB   3
`define HKA_RESET_BYTE       8'h00
`define HKA_DELTA_NEVER      3'h0
`define HKA_DELTA_ALWAYS     3'h7
`define HKA_CLK_PERIOD_NS    8
`define HKA_SEC_NS           1000000000
`define HKA_SEC_CYCLES       (`HKA_SEC_NS / `HKA_CLK_PERIOD_NS)
`define HKA_SEC_PER_MIN      60
`define HKA_TEMP_INT1_MIN    8
`define HKA_TEMP_INT2_MIN    2
`define HKA_TEMP_INT3_MIN    1
`define HKA_BATT_INT1_MIN    16
`define HKA_BATT_INT2_MIN    4
`define HKA_BATT_INT3_MIN    1
`endif

// File: design/hka_pkg.sv
// types shared by the housekeeping converter sequencer
package hka_pkg;
   typedef enum logic [1:0] {
      PM_FULL_POWER = 2'b00,
      PM_BATTERY    = 2'b01,
      PM_SLEEP      = 2'b10
   } hka_pm_t;
   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,
      CH_REQ  = 2'b01,
      CH_WAIT = 2'b10
   } hka_ch_state_t;
   typedef struct packed {
      logic       accept;
      logic       done;
      logic [7:0] data;
   } hka_conv_rsp_t;
   typedef struct packed {
      logic single;
      logic backgr;
   } hka_src_t;
   function automatic logic [7:0] hka_absdiff(input logic [7:0] a, input logic [7:0] b);
      hka_absdiff = (a > b) ? (a - b) : (b - a);
   endfunction : hka_absdiff
endpackage : hka_pkg

// File: design/hka_conv_chan.sv
// one converter port: serialises single-shot and background requests
`timescale 1ns/1ps
`default_nettype none
module hka_conv_chan (
   input  wire logic                   clk_in,
   input  wire logic                   resetn_in,
   input  wire logic                   ce_in,
   input  wire logic                   single_in,
   input  wire logic                   backgr_in,
   input  wire hka_pkg::hka_conv_rsp_t rsp_in,
   output logic                        req_out,
   output hka_pkg::hka_src_t           taken_out,
   output hka_pkg::hka_src_t           done_out
);
   hka_pkg::hka_ch_state_t state_q, state_d;
   logic                   src_single_q, src_single_d;

   // single-shot wins a tie: software is waiting on it
   wire pick        = single_in | backgr_in;
   wire accepted    = (state_q == hka_pkg::CH_REQ) & rsp_in.accept;
   wire finished    = (state_q == hka_pkg::CH_WAIT) & rsp_in.done;

   assign req_out          = (state_q == hka_pkg::CH_REQ);
   assign taken_out.single = accepted & src_single_q;
   assign taken_out.backgr = accepted & ~src_single_q;
   assign done_out.single  = finished & src_single_q;
   assign done_out.backgr  = finished & ~src_single_q;

   always_comb begin
      state_d      = state_q;
      src_single_d = src_single_q;
      case (state_q)
         hka_pkg::CH_IDLE: begin
            if (pick) begin
               state_d      = hka_pkg::CH_REQ;
               src_single_d = single_in;
            end
         end
         hka_pkg::CH_REQ:  if (rsp_in.accept) state_d = hka_pkg::CH_WAIT;
         hka_pkg::CH_WAIT: if (rsp_in.done) state_d = hka_pkg::CH_IDLE;
         default:          state_d = hka_pkg::CH_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q      <= hka_pkg::CH_IDLE;
         src_single_q <= 1'b0;
      end else if (ce_in) begin
         state_q      <= state_d;
         src_single_q <= src_single_d;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   property p_req_hold;
      req_out && !rsp_in.accept && ce_in |=> req_out;
   endproperty
   a_req_hold: assert property (p_req_hold)
      else $error("request dropped before acceptance");
   property p_one_outstanding;
      req_out && rsp_in.accept && ce_in |=> !req_out [*2];
   endproperty
   a_one_outstanding: assert property (p_one_outstanding)
      else $error("second request issued while one is outstanding");
endmodule : hka_conv_chan
`default_nettype wire

// File: design/hka_interval_tmr.sv
// background strobe: counts seconds and ticks at the selected interval
`timescale 1ns/1ps
`default_nettype none
`include "hka_map.svh"
module hka_interval_tmr #(
   parameter int unsigned P1_MIN      = `HKA_TEMP_INT1_MIN,
   parameter int unsigned P2_MIN      = `HKA_TEMP_INT2_MIN,
   parameter int unsigned P3_MIN      = `HKA_TEMP_INT3_MIN,
   parameter int unsigned SEC_PER_MIN = `HKA_SEC_PER_MIN
) (
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   input  wire logic       ce_in,
   input  wire logic       sec_tick_in,
   input  wire logic [1:0] sel_in,
   output logic            tick_out
);
   localparam int unsigned CW = $clog2(P1_MIN * SEC_PER_MIN + 1);

   function automatic logic [CW-1:0] limit_of(input logic [1:0] sel);
      case (sel)
         2'h1:    limit_of = CW'(P1_MIN * SEC_PER_MIN - 1);
         2'h2:    limit_of = CW'(P2_MIN * SEC_PER_MIN - 1);
         2'h3:    limit_of = CW'(P3_MIN * SEC_PER_MIN - 1);
         default: limit_of = '0;
      endcase
   endfunction : limit_of

   logic [CW-1:0] cnt_q, cnt_d;
   // >= so that a shorter interval chosen mid-count fires on the next second tick
   wire           at_limit = (cnt_q >= limit_of(sel_in));
   wire           off      = (sel_in == 2'h0);

   assign tick_out = sec_tick_in & at_limit & ~off;
   assign cnt_d    = off ? '0 : (sec_tick_in ? (at_limit ? '0 : cnt_q + 1'b1) : cnt_q);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) cnt_q <= '0;
      else if (ce_in) cnt_q <= cnt_d;
   end
endmodule : hka_interval_tmr
`default_nettype wire

// File: design/hka_seq_top.sv
// housekeeping converter sequencer: register slice, scheduling, result handling
`timescale 1ns/1ps
`default_nettype none
`include "hka_map.svh"
// Notes on behaviour
// - writing one to start bit 2 requests one external voltage conversion.
// - writing one to start bit 1 requests one temperature conversion.
// - writing one to start bit 0 requests one battery conversion.
// - start bits read one until the converter accepts, then clear themselves.
// - writing one to start bit 7 clears the pll fault flag.
// - start bits 6 to 3 read zero and ignore writes.
// - result registers load only when their converter interrupt fires.
// - finished single temperature conversion loads result and raises interrupt.
// - background temperature conversions off until a nonzero interval is chosen.
// - background temperature interrupts only when change from reference exceeds delta, or when delta is 7.
// - temperature interrupt is delta hit or single completion, no flag.
// - full power mode allows background and single temperature conversions.
// - battery mode allows only single temperature conversions.
// - sleep mode allows only background temperature conversions.
// - temperature code is 8 bits, 0.78 degrees per step.
// - battery code is 8 bits, 14.6 mV per step.
// - finished single battery conversion loads result and sets the low battery flag.
// - battery conversions repeat at the selected battery interval, in full power mode only.
// - battery code below threshold sets the low battery flag.
// - low battery flag reaches power interrupt only when enabled.
// - temperature interval codes: off, 8, 2 and 1 minutes.
// - battery interval codes: off, 16, 4 and 1 minutes.
// - delta 0 never interrupts, 1 to 6 threshold, 7 always.
module hka_seq_top #(
   parameter int unsigned SEC_CYCLES = `HKA_SEC_CYCLES
) (
   input  wire logic                   clk_in,
   input  wire logic                   resetn_in,
   input  wire logic                   ce_in,
   input  wire hka_pkg::hka_pm_t       pm_mode_in,
   input  wire logic [7:0]             sfr_addr_in,
   input  wire logic                   sfr_wr_in,
   input  wire logic [7:0]             sfr_wdata_in,
   input  wire logic                   sfr_rd_in,
   output logic [7:0]                  sfr_rdata_out,
   input  wire logic                   pll_fault_in,
   output logic                        pll_fault_flag_out,
   output logic                        temp_req_out,
   input  wire hka_pkg::hka_conv_rsp_t temp_rsp_in,
   output logic                        batt_req_out,
   input  wire hka_pkg::hka_conv_rsp_t batt_rsp_in,
   output logic                        ext_req_out,
   input  wire hka_pkg::hka_conv_rsp_t ext_rsp_in,
   output logic                        temp_irq_out,
   output logic                        ext_irq_out,
   output logic                        psm_irq_out
);
   localparam int unsigned SW = $clog2(SEC_CYCLES);

   // register state
   logic [2:0]        start_q, start_d;
   logic              pll_fault_flag_q, pll_fault_flag_d;
   logic [3:0]        strobe_q;
   logic [2:0]        tdelta_q;
   logic [7:0]        thresh_q;
   logic              batt_en_q;
   logic              batt_low_q, batt_low_d;
   logic [7:0]        temp_res_q;
   logic [7:0]        batt_res_q;
   logic [7:0]        ext_res_q;
   logic [7:0]        tref_q;
   logic              temp_irq_q;
   logic              ext_irq_q;
   logic [7:0]        rdata_q;
   logic [SW-1:0]     sec_cnt_q;
   logic              tbg_pend_q, tbg_pend_d;
   logic              bbg_pend_q, bbg_pend_d;
   hka_pkg::hka_src_t temp_tkn, temp_dn;
   hka_pkg::hka_src_t batt_tkn, batt_dn;
   hka_pkg::hka_src_t ext_tkn, ext_dn;
   logic              temp_tick, batt_tick;

   // register writes
   wire wr_en     = ce_in & sfr_wr_in;
   wire wr_start  = wr_en & (sfr_addr_in == `HKA_ADDR_START);
   wire wr_strobe = wr_en & (sfr_addr_in == `HKA_ADDR_STROBE);
   wire wr_delta  = wr_en & (sfr_addr_in == `HKA_ADDR_DELTA);
   wire wr_thresh = wr_en & (sfr_addr_in == `HKA_ADDR_BATT_THRESH);
   wire wr_pen    = wr_en & (sfr_addr_in == `HKA_ADDR_PIRQ_EN);
   wire wr_pflag  = wr_en & (sfr_addr_in == `HKA_ADDR_PIRQ_FLAGS);

   // mode gating of request sources
   wire is_full       = (pm_mode_in == hka_pkg::PM_FULL_POWER);
   wire is_sleep      = (pm_mode_in == hka_pkg::PM_SLEEP);
   wire single_ok     = ~is_sleep;
   wire temp_bg_ok    = is_full | is_sleep;
   wire batt_bg_ok    = is_full;

   // start bits: a fresh write beats the self-clear of the same cycle
   wire [2:0] tkn_single = {ext_tkn.single, temp_tkn.single, batt_tkn.single};
   wire [2:0] go_wr      = wr_start ? sfr_wdata_in[2:0] : 3'h0;
   assign start_d   = go_wr | (start_q & ~tkn_single);
   wire   pll_ack   = wr_start & sfr_wdata_in[`HKA_BIT_PLL_ACK];
   assign pll_fault_flag_d = pll_fault_in | (pll_fault_flag_q & ~pll_ack);

   // one-second prescaler shared by both interval timers
   wire sec_tick = (sec_cnt_q == SW'(SEC_CYCLES - 1));

   // temperature completion and delta test
   wire [7:0] t_diff = hka_pkg::hka_absdiff(temp_rsp_in.data, tref_q);
   wire       t_hit  = (tdelta_q == `HKA_DELTA_ALWAYS) |
                       ((tdelta_q != `HKA_DELTA_NEVER) & (t_diff > {5'h0, tdelta_q}));
   wire       t_fire = temp_dn.single | (temp_dn.backgr & t_hit);

   // battery completion and threshold test
   wire b_low  = (batt_rsp_in.data < thresh_q);
   wire b_fire = batt_dn.single | ((batt_dn.single | batt_dn.backgr) & b_low);
   wire e_fire = ext_dn.single;

   // background pending: dropped while the mode forbids it, so no stale burst later
   assign tbg_pend_d = temp_tick | (tbg_pend_q & temp_bg_ok & ~temp_tkn.backgr);
   assign bbg_pend_d = batt_tick | (bbg_pend_q & batt_bg_ok & ~batt_tkn.backgr);

   // power flag: software writes zero to clear, a new event wins
   wire pflag_clr = wr_pflag & ~sfr_wdata_in[`HKA_BIT_BATT_LOW];
   assign batt_low_d = b_fire | (batt_low_q & ~pflag_clr);

   // register read mux; reserved and unmapped bits read zero
   wire [7:0] start_rd  = {5'h00, start_q};
   wire [7:0] peripheral_config_reg_rd = {3'h0, pll_fault_flag_q, 4'h0};
   wire [7:0] pflag_rd  = {5'h00, batt_low_q, 2'h0};
   wire [7:0] pen_rd    = {5'h00, batt_en_q, 2'h0};
   wire [7:0] rd_mux =
      (sfr_addr_in == `HKA_ADDR_TEMP_RESULT) ? temp_res_q :
      (sfr_addr_in == `HKA_ADDR_START)       ? start_rd   :
      (sfr_addr_in == `HKA_ADDR_BATT_RESULT) ? batt_res_q :
      (sfr_addr_in == `HKA_ADDR_EXT_RESULT)  ? ext_res_q  :
      (sfr_addr_in == `HKA_ADDR_BATT_THRESH) ? thresh_q   :
      (sfr_addr_in == `HKA_ADDR_STROBE)      ? {4'h0, strobe_q} :
      (sfr_addr_in == `HKA_ADDR_DELTA)       ? {2'h0, tdelta_q, 3'h0} :
      (sfr_addr_in == `HKA_ADDR_PERIPHERAL_CONFIG_REG)      ? peripheral_config_reg_rd  :
      (sfr_addr_in == `HKA_ADDR_PIRQ_FLAGS)  ? pflag_rd   :
      (sfr_addr_in == `HKA_ADDR_PIRQ_EN)     ? pen_rd     : `HKA_RESET_BYTE;

   assign sfr_rdata_out      = rdata_q;
   assign pll_fault_flag_out = pll_fault_flag_q;
   assign temp_irq_out       = temp_irq_q;
   assign ext_irq_out        = ext_irq_q;
   assign psm_irq_out        = batt_low_q & batt_en_q;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         start_q    <= 3'h0;
         pll_fault_flag_q  <= 1'b0;
         batt_low_q <= 1'b0;
         tbg_pend_q <= 1'b0;
         bbg_pend_q <= 1'b0;
         sec_cnt_q  <= '0;
         rdata_q    <= `HKA_RESET_BYTE;
      end else if (ce_in) begin
         start_q    <= start_d;
         pll_fault_flag_q  <= pll_fault_flag_d;
         batt_low_q <= batt_low_d;
         tbg_pend_q <= tbg_pend_d;
         bbg_pend_q <= bbg_pend_d;
         sec_cnt_q  <= sec_tick ? '0 : sec_cnt_q + 1'b1;
         if (sfr_rd_in) rdata_q <= rd_mux;
      end
   end

   // configuration registers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         strobe_q  <= 4'h0;
         tdelta_q  <= `HKA_DELTA_NEVER;
         thresh_q  <= `HKA_RESET_BYTE;
         batt_en_q <= 1'b0;
      end else if (ce_in) begin
         if (wr_strobe) strobe_q <= sfr_wdata_in[3:0];
         if (wr_delta) tdelta_q <= sfr_wdata_in[`HKA_DELTA_TEMP_LSB +: 3];
         if (wr_thresh) thresh_q <= sfr_wdata_in;
         if (wr_pen) batt_en_q <= sfr_wdata_in[`HKA_BIT_BATT_LOW];
      end
   end

   // results: 0.78 C and 14.6 mV per code step, loaded only on interrupt
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         temp_res_q <= `HKA_RESET_BYTE;
         tref_q     <= `HKA_RESET_BYTE;
         batt_res_q <= `HKA_RESET_BYTE;
         ext_res_q  <= `HKA_RESET_BYTE;
         temp_irq_q <= 1'b0;
         ext_irq_q  <= 1'b0;
      end else if (ce_in) begin
         temp_irq_q <= t_fire;
         ext_irq_q  <= e_fire;
         if (t_fire) temp_res_q <= temp_rsp_in.data;
         if (t_fire) tref_q <= temp_rsp_in.data;
         if (b_fire) batt_res_q <= batt_rsp_in.data;
         if (e_fire) ext_res_q <= ext_rsp_in.data;
      end
   end

   hka_interval_tmr #(
      .P1_MIN      (`HKA_TEMP_INT1_MIN),
      .P2_MIN      (`HKA_TEMP_INT2_MIN),
      .P3_MIN      (`HKA_TEMP_INT3_MIN),
      .SEC_PER_MIN (`HKA_SEC_PER_MIN)
   ) u_temp_tmr (
      .clk_in      (clk_in),
      .resetn_in   (resetn_in),
      .ce_in       (ce_in),
      .sec_tick_in (sec_tick),
      .sel_in      (strobe_q[`HKA_STRB_TEMP_LSB +: 2]),
      .tick_out    (temp_tick)
   );

   hka_interval_tmr #(
      .P1_MIN      (`HKA_BATT_INT1_MIN),
      .P2_MIN      (`HKA_BATT_INT2_MIN),
      .P3_MIN      (`HKA_BATT_INT3_MIN),
      .SEC_PER_MIN (`HKA_SEC_PER_MIN)
   ) u_batt_tmr (
      .clk_in      (clk_in),
      .resetn_in   (resetn_in),
      .ce_in       (ce_in),
      .sec_tick_in (sec_tick),
      .sel_in      (strobe_q[`HKA_STRB_BATT_LSB +: 2]),
      .tick_out    (batt_tick)
   );

   hka_conv_chan u_temp_chan (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .ce_in     (ce_in),
      .single_in (start_q[`HKA_BIT_TEMP_GO] & single_ok),
      .backgr_in (tbg_pend_q & temp_bg_ok),
      .rsp_in    (temp_rsp_in),
      .req_out   (temp_req_out),
      .taken_out (temp_tkn),
      .done_out  (temp_dn)
   );

   hka_conv_chan u_batt_chan (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .ce_in     (ce_in),
      .single_in (start_q[`HKA_BIT_BATT_GO] & single_ok),
      .backgr_in (bbg_pend_q & batt_bg_ok),
      .rsp_in    (batt_rsp_in),
      .req_out   (batt_req_out),
      .taken_out (batt_tkn),
      .done_out  (batt_dn)
   );

   // background path for external voltage is not part of this block
   hka_conv_chan u_ext_chan (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .ce_in     (ce_in),
      .single_in (start_q[`HKA_BIT_EXT_GO] & single_ok),
      .backgr_in (1'b0),
      .rsp_in    (ext_rsp_in),
      .req_out   (ext_req_out),
      .taken_out (ext_tkn),
      .done_out  (ext_dn)
   );

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   property p_start_set;
      ce_in && wr_start && sfr_wdata_in[1] |=> start_q[1];
   endproperty
   a_start_set: assert property (p_start_set)
      else $error("temperature start bit not set by write");
   property p_start_clear;
      ce_in && temp_tkn.single && !(wr_start && sfr_wdata_in[1]) |=> !start_q[1];
   endproperty
   a_start_clear: assert property (p_start_clear)
      else $error("temperature start bit not cleared on acceptance");
   property p_reserved;
      ce_in && sfr_rd_in && sfr_addr_in == `HKA_ADDR_START |=> sfr_rdata_out[6:3] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved start bits read nonzero");
   property p_pll_clear;
      ce_in && pll_ack && !pll_fault_in |=> !pll_fault_flag_out;
   endproperty
   a_pll_clear: assert property (p_pll_clear)
      else $error("pll fault flag not cleared");
   property p_temp_hold;
      ce_in && !t_fire |=> $stable(temp_res_q);
   endproperty
   a_temp_hold: assert property (p_temp_hold)
      else $error("temperature result changed without interrupt");
   property p_temp_single;
      ce_in && temp_dn.single |=> temp_irq_out && temp_res_q == $past(temp_rsp_in.data);
   endproperty
   a_temp_single: assert property (p_temp_single)
      else $error("single temperature completion not reported");
   property p_delta_never;
      ce_in && temp_dn.backgr && tdelta_q == `HKA_DELTA_NEVER |=> !temp_irq_out;
   endproperty
   a_delta_never: assert property (p_delta_never)
      else $error("interrupt with delta setting zero");
   property p_batt_low;
      ce_in && batt_dn.backgr && batt_rsp_in.data < thresh_q |=> batt_low_q;
   endproperty
   a_batt_low: assert property (p_batt_low)
      else $error("low battery flag not set");
   property p_psm_irq;
      ce_in && b_fire && batt_en_q && !wr_pen |=> psm_irq_out;
   endproperty
   a_psm_irq: assert property (p_psm_irq)
      else $error("power interrupt missing while enabled");

   c_temp_delta: cover property (ce_in && temp_dn.backgr && t_hit);
   c_batt_low: cover property (ce_in && batt_dn.backgr && b_low);
   c_ext_single: cover property (ce_in && ext_dn.single);
endmodule : hka_seq_top
`default_nettype wire

// File: tb/hka_conv_model.sv
// behavioural housekeeping converter: accepts a request, answers with one code later
`timescale 1ns/1ps
`default_nettype none
module hka_conv_model #(
   parameter int unsigned ACC  = 2,
   parameter int unsigned CONV = 5
) (
   input  wire logic                   clk_in,
   input  wire logic                   resetn_in,
   input  wire logic                   req_in,
   input  wire logic [7:0]             code_in,
   output hka_pkg::hka_conv_rsp_t      rsp_out
);
   logic [3:0] cnt_q;
   logic       busy_q;
   logic [7:0] last_q;
   always @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_q   <= 4'h0;
         busy_q  <= 1'b0;
         last_q  <= 8'h00;
         rsp_out <= '0;
      end else begin
         rsp_out.accept <= 1'b0;
         rsp_out.done   <= 1'b0;
         // data outside done is the inverse of the last code, never a stale match
         rsp_out.data   <= ~last_q;
         if (!busy_q && req_in) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'(ACC)) begin
               rsp_out.accept <= 1'b1;
               busy_q         <= 1'b1;
               cnt_q          <= 4'h0;
            end
         end else if (busy_q) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'(CONV)) begin
               rsp_out.done <= 1'b1;
               rsp_out.data <= code_in;
               last_q       <= code_in;
               busy_q       <= 1'b0;
               cnt_q        <= 4'h0;
            end
         end
      end
   end
endmodule : hka_conv_model
`default_nettype wire

// File: tb/housekeeping_adc_sequencer_tb_top.sv
// testbench: register accesses, converter traffic, background scheduling
`timescale 1ns/1ps
`default_nettype none
module housekeeping_adc_sequencer_tb_top;
   logic                   clk_in, resetn_in, wr, rd, pll, t_req, b_req, e_req, ce;
   logic                   t_irq, e_irq, p_irq, pll_flag;
   logic [7:0]             addr, wdata, rdata, t_code, b_code, e_code;
   hka_pkg::hka_pm_t       pm;
   hka_pkg::hka_conv_rsp_t t_rsp, b_rsp, e_rsp;
   int                     mismatches, tests_run, n_tirq, n_eirq, n_tdone, cyc, last_d, gap;
   hka_seq_top #(.SEC_CYCLES(4)) uut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce),
      .pm_mode_in(pm), .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
      .sfr_rd_in(rd), .sfr_rdata_out(rdata), .pll_fault_in(pll),
      .pll_fault_flag_out(pll_flag), .temp_req_out(t_req), .temp_rsp_in(t_rsp),
      .batt_req_out(b_req), .batt_rsp_in(b_rsp), .ext_req_out(e_req), .ext_rsp_in(e_rsp),
      .temp_irq_out(t_irq), .ext_irq_out(e_irq), .psm_irq_out(p_irq));
   hka_conv_model #(.ACC(2)) m_t (.clk_in(clk_in), .resetn_in(resetn_in), .req_in(t_req),
      .code_in(t_code), .rsp_out(t_rsp));
   // slower accept on the battery side
   hka_conv_model #(.ACC(5)) m_b (.clk_in(clk_in), .resetn_in(resetn_in), .req_in(b_req),
      .code_in(b_code), .rsp_out(b_rsp));
   hka_conv_model #(.ACC(0)) m_e (.clk_in(clk_in), .resetn_in(resetn_in), .req_in(e_req),
      .code_in(e_code), .rsp_out(e_rsp));
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc++;
      if (t_irq === 1'b1) n_tirq++;
      if (e_irq === 1'b1) n_eirq++;
      if (t_rsp.done === 1'b1) begin
         n_tdone++;
         gap = cyc - last_d;
         last_d = cyc;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk_in);
      #1;
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk_in);
      #1;
      rd = 1'b0;
      chk(rdata, exp);
   endtask : rd_chk
   // waits for the next temperature completion, bounded at 600 cycles, beyond the 1- and 2-minute intervals but not the 8-minute one
   task automatic next_bg;
      int n0;
      n0 = n_tdone;
      for (int i = 0; i < 600 && n_tdone == n0; i++) @(posedge clk_in);
      repeat (3) @(posedge clk_in);
      #1;
   endtask : next_bg
   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results
   initial begin
      #200000;
      mismatches++;
      results();
   end
   initial begin
      resetn_in = 1'b0;
      {wr, rd, pll, ce} = 4'b0001;
      {addr, wdata} = 16'h0000;
      {t_code, b_code, e_code} = 24'h000000;
      pm = hka_pkg::PM_FULL_POWER;
      repeat (16) @(posedge clk_in);
      #1;
      resetn_in = 1'b1;
      rd_chk(8'hD7, 8'h00);
      rd_chk(8'hD8, 8'h00);
      rd_chk(8'hDF, 8'h00);
      rd_chk(8'hEF, 8'h00);
      rd_chk(8'hFA, 8'h00);
      rd_chk(8'h80, 8'h00);
      // frozen block must not take the start write
      ce = 1'b0;
      wr_reg(8'hD8, 8'h02);
      ce = 1'b1;
      rd_chk(8'hD8, 8'h00);
      t_code = 8'h50;
      wr_reg(8'hD8, 8'h7A);
      rd_chk(8'hD8, 8'h02);
      repeat (20) @(posedge clk_in);
      chk(8'(n_tirq), 8'h01);
      rd_chk(8'hD7, 8'h50);
      rd_chk(8'hD8, 8'h00);
      wr_reg(8'hFA, 8'h80);
      b_code = 8'h40;
      wr_reg(8'hD8, 8'h01);
      repeat (20) @(posedge clk_in);
      rd_chk(8'hDF, 8'h40);
      rd_chk(8'hF8, 8'h04);
      chk({7'h00, p_irq}, 8'h00);
      wr_reg(8'hEC, 8'h04);
      chk({7'h00, p_irq}, 8'h01);
      e_code = 8'hA5;
      wr_reg(8'hD8, 8'h04);
      repeat (20) @(posedge clk_in);
      rd_chk(8'hEF, 8'hA5);
      chk(8'(n_eirq), 8'h01);
      pll = 1'b1;
      @(posedge clk_in);
      #1;
      pll = 1'b0;
      chk({7'h00, pll_flag}, 8'h01);
      wr_reg(8'hD8, 8'h80);
      chk({7'h00, pll_flag}, 8'h00);
      chk(8'(n_tdone), 8'h01);
      wr_reg(8'hF3, 8'h10);
      t_code = 8'h52;
      wr_reg(8'hF9, 8'h03);
      next_bg();
      next_bg();
      chk(8'(gap), 8'hF0);
      chk(8'(n_tirq), 8'h01);
      t_code = 8'h53;
      next_bg();
      chk(8'(n_tirq), 8'h02);
      rd_chk(8'hD7, 8'h53);
      t_code = 8'h55;
      next_bg();
      chk(8'(n_tirq), 8'h02);
      wr_reg(8'hF3, 8'h38);
      next_bg();
      chk(8'(n_tirq), 8'h03);
      wr_reg(8'hF3, 8'h00);
      t_code = 8'h00;
      next_bg();
      chk(8'(n_tirq), 8'h03);
      wr_reg(8'hF3, 8'h38);
      pm = hka_pkg::PM_BATTERY;
      next_bg();
      chk(8'(n_tdone), 8'h07);
      wr_reg(8'hD8, 8'h02);
      repeat (20) @(posedge clk_in);
      chk(8'(n_tirq), 8'h04);
      pm = hka_pkg::PM_SLEEP;
      next_bg();
      chk(8'(n_tirq), 8'h05);
      // background battery path, flag cleared first so the new set is visible
      pm = hka_pkg::PM_FULL_POWER;
      b_code = 8'h30;
      wr_reg(8'hF8, 8'h00);
      rd_chk(8'hF8, 8'h00);
      chk({7'h00, p_irq}, 8'h00);
      wr_reg(8'hF9, 8'h0C);
      repeat (300) @(posedge clk_in);
      #1;
      rd_chk(8'hDF, 8'h30);
      rd_chk(8'hF8, 8'h04);
      chk({7'h00, p_irq}, 8'h01);
      results();
   end
endmodule : housekeeping_adc_sequencer_tb_top
`default_nettype wire
